// ### usbf_pkg.sv
// Package with register map, field positions and carrier types for the USB FIFO status-flag block.
package usbf_pkg;
    localparam int DATA_W = 8;
    localparam int ADDR_W = 8;
    localparam int CNT_W = 7;

    localparam logic [ADDR_W-1:0] ADDR_STATUS = 8'h00;
    localparam logic [ADDR_W-1:0] ADDR_DATA_END = 8'h01;
    localparam logic [ADDR_W-1:0] ADDR_INT_STATUS = 8'h02;
    localparam logic [ADDR_W-1:0] ADDR_INT_MASK = 8'h03;

    localparam int BIT_CONTROL_TX_DATA_END_CMD = 1;
    localparam int BIT_BULK_IN_DATA_END_CMD = 2;

    localparam logic [DATA_W-1:0] STATUS_RESET = 8'h00;
    localparam logic [DATA_W-1:0] READ_ZERO = 8'h00;
    localparam logic [CNT_W-1:0] COUNT_EMPTY = 7'h00;
    localparam logic [3:0] INT_RESET = 4'h0;

    // Flag status register layout, bit 7 down to bit 0.
    typedef struct packed {
        logic [2:0] zero_hi;
        logic bulk_out_data_present;
        logic zero_mid;
        logic bulk_in_data_present;
        logic control_tx_data_present;
        logic control_rx_data_present;
    } usbf_status_type;

    // Interrupt event layout, shared by status and mask registers.
    typedef struct packed {
        logic control_tx_done;
        logic bulk_in_toggled;
        logic control_rx_ready;
        logic bulk_out_ready;
    } usbf_int_type;

    // Receive-side report from the serial engine for one finished packet.
    typedef struct packed {
        logic done;
        logic zero_length;
    } usbf_rx_pkt_type;
endpackage

// ### usbf_flag.sv
// Sticky flag with set and clear, where a set in the clearing cycle wins.
`timescale 1ns/1ns
module usbf_flag (
    input wire logic clk,
    input wire logic rst_b,
    input wire logic set,
    input wire logic clr,
    output logic q
);
    logic q_reg;
    logic q_next;

    always_comb begin
        q_next = q_reg;
        if (clr) begin
            q_next = 1'b0;
        end
        if (set) begin
            q_next = 1'b1;
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_b) begin
            q_reg <= 1'b0;
        end else begin
            q_reg <= q_next;
        end
    end

    assign q = q_reg;
endmodule

// ### usbf_eps.sv
// FIFO data-present status flags, data-end command, interrupt logic and CPU register port.
`timescale 1ns/1ns
module usbf_eps (
    input wire logic clk,
    input wire logic rst_b,
    input wire logic [usbf_pkg::ADDR_W-1:0] addr,
    input wire logic [usbf_pkg::DATA_W-1:0] wdata,
    input wire logic wr,
    input wire logic rd,
    output logic [usbf_pkg::DATA_W-1:0] rdata,
    output logic irq,
    input wire usbf_pkg::usbf_rx_pkt_type bulk_out_pkt,
    input wire logic bulk_out_cpu_read,
    input wire logic [usbf_pkg::CNT_W-1:0] bulk_out_count,
    output logic bulk_out_fifo_toggle,
    input wire usbf_pkg::usbf_rx_pkt_type control_rx_pkt,
    input wire logic control_rx_cpu_read,
    input wire logic [usbf_pkg::CNT_W-1:0] control_rx_count,
    input wire logic [usbf_pkg::CNT_W-1:0] bulk_in_count,
    input wire logic bulk_in_sie_empty,
    output logic bulk_in_fifo_toggle,
    input wire logic control_tx_ok
);
    logic bulk_out_data_present;
    logic bulk_in_data_present;
    logic control_tx_data_present;
    logic control_rx_data_present;
    logic bulk_out_set;
    logic bulk_out_clr;
    logic bulk_in_set;
    logic bulk_in_clr;
    logic control_tx_set;
    logic control_rx_set;
    logic control_rx_clr;
    logic wr_data_end;
    logic bulk_in_data_end_cmd;
    logic control_tx_data_end_cmd;
    logic bulk_out_pending_reg;
    logic bulk_out_pending_next;
    logic bulk_out_read_seen_reg;
    logic bulk_out_read_seen_next;
    logic control_rx_read_seen_reg;
    logic control_rx_read_seen_next;
    logic bulk_out_toggle_now;
    logic bulk_in_toggle_now;
    logic bulk_out_toggle_reg;
    logic bulk_out_toggle_next;
    logic bulk_in_toggle_reg;
    logic bulk_in_toggle_next;
    usbf_pkg::usbf_int_type int_status_reg;
    usbf_pkg::usbf_int_type int_status_next;
    usbf_pkg::usbf_int_type int_mask_reg;
    usbf_pkg::usbf_int_type int_mask_next;
    usbf_pkg::usbf_int_type int_event;
    usbf_pkg::usbf_int_type int_w1c;
    usbf_pkg::usbf_status_type status;
    logic [usbf_pkg::DATA_W-1:0] rdata_reg;
    logic [usbf_pkg::DATA_W-1:0] rdata_next;
    logic irq_reg;
    logic irq_next;

    // Data-end command bits act only in the write cycle; they read back as zero.
    always_comb begin
        wr_data_end = wr && (addr == usbf_pkg::ADDR_DATA_END);
        bulk_in_data_end_cmd = wr_data_end && wdata[usbf_pkg::BIT_BULK_IN_DATA_END_CMD];
        control_tx_data_end_cmd = wr_data_end && wdata[usbf_pkg::BIT_CONTROL_TX_DATA_END_CMD];
    end

    // A received packet waits on the engine side until the CPU side is free, then the FIFO toggles.
    always_comb begin
        bulk_out_pending_next = bulk_out_pending_reg;
        bulk_out_toggle_now = bulk_out_pending_reg && !bulk_out_data_present;
        if (bulk_out_toggle_now) begin
            bulk_out_pending_next = 1'b0;
        end
        // A packet that finishes in the toggle cycle stays pending, so it is never lost.
        if (bulk_out_pkt.done && !bulk_out_pkt.zero_length) begin
            bulk_out_pending_next = 1'b1;
        end
        bulk_out_toggle_next = bulk_out_toggle_now;
        bulk_out_set = bulk_out_toggle_now;
    end

    // After a CPU read, the flag drains once the counter is at zero, now or in a later cycle.
    always_comb begin
        bulk_out_read_seen_next = bulk_out_read_seen_reg;
        if (bulk_out_cpu_read) begin
            bulk_out_read_seen_next = 1'b1;
        end
        if (bulk_out_toggle_now || !bulk_out_data_present) begin
            bulk_out_read_seen_next = 1'b0;
        end
        bulk_out_clr = bulk_out_read_seen_reg && (bulk_out_count == usbf_pkg::COUNT_EMPTY);
    end

    // Bulk-in: the data-end command marks the CPU side full; it moves to the engine when that side is empty.
    always_comb begin
        bulk_in_set = bulk_in_data_end_cmd && (bulk_in_count == usbf_pkg::COUNT_EMPTY);
        if (bulk_in_data_end_cmd) begin
            bulk_in_set = 1'b1;
        end
        bulk_in_toggle_now = bulk_in_data_present && bulk_in_sie_empty;
        bulk_in_clr = bulk_in_toggle_now;
        bulk_in_toggle_next = bulk_in_toggle_now;
    end

    // Control transmit and receive flags.
    always_comb begin
        control_tx_set = control_tx_data_end_cmd;
        control_rx_set = control_rx_pkt.done && !control_rx_pkt.zero_length;
        control_rx_read_seen_next = control_rx_read_seen_reg;
        if (control_rx_cpu_read) begin
            control_rx_read_seen_next = 1'b1;
        end
        if (control_rx_set || !control_rx_data_present) begin
            control_rx_read_seen_next = 1'b0;
        end
        control_rx_clr = control_rx_read_seen_reg && (control_rx_count == usbf_pkg::COUNT_EMPTY);
    end

    usbf_flag u_bulk_out (
        .clk(clk),
        .rst_b(rst_b),
        .set(bulk_out_set),
        .clr(bulk_out_clr),
        .q(bulk_out_data_present)
    );

    usbf_flag u_bulk_in (
        .clk(clk),
        .rst_b(rst_b),
        .set(bulk_in_set),
        .clr(bulk_in_clr),
        .q(bulk_in_data_present)
    );

    usbf_flag u_control_tx (
        .clk(clk),
        .rst_b(rst_b),
        .set(control_tx_set),
        .clr(control_tx_ok),
        .q(control_tx_data_present)
    );

    usbf_flag u_control_rx (
        .clk(clk),
        .rst_b(rst_b),
        .set(control_rx_set),
        .clr(control_rx_clr),
        .q(control_rx_data_present)
    );

    // Interrupt events: sticky, cleared by writing one, a new event wins over the clear.
    always_comb begin
        int_event.bulk_out_ready = bulk_out_set;
        int_event.control_rx_ready = control_rx_set;
        int_event.bulk_in_toggled = bulk_in_toggle_now;
        int_event.control_tx_done = control_tx_ok && control_tx_data_present;
        int_w1c = (wr && (addr == usbf_pkg::ADDR_INT_STATUS)) ? usbf_pkg::usbf_int_type'(wdata[3:0])
                                                                : usbf_pkg::INT_RESET;
        int_status_next = (int_status_reg & ~int_w1c) | int_event;
        int_mask_next = int_mask_reg;
        if (wr && (addr == usbf_pkg::ADDR_INT_MASK)) begin
            int_mask_next = usbf_pkg::usbf_int_type'(wdata[3:0]);
        end
        irq_next = |(int_status_next & int_mask_next);
    end

    // Read port: data stand in the cycle after the strobe; the flag register cannot be written.
    always_comb begin
        status = '0;
        status.bulk_out_data_present = bulk_out_data_present;
        status.bulk_in_data_present = bulk_in_data_present;
        status.control_tx_data_present = control_tx_data_present;
        status.control_rx_data_present = control_rx_data_present;
        rdata_next = usbf_pkg::READ_ZERO;
        if (rd) begin
            case (addr)
                usbf_pkg::ADDR_STATUS: begin
                    rdata_next = status;
                end
                usbf_pkg::ADDR_INT_STATUS: begin
                    rdata_next = {4'h0, int_status_reg};
                end
                usbf_pkg::ADDR_INT_MASK: begin
                    rdata_next = {4'h0, int_mask_reg};
                end
                default: begin
                    rdata_next = usbf_pkg::READ_ZERO;
                end
            endcase
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_b) begin
            bulk_out_pending_reg <= 1'b0;
            bulk_out_read_seen_reg <= 1'b0;
            control_rx_read_seen_reg <= 1'b0;
            bulk_out_toggle_reg <= 1'b0;
            bulk_in_toggle_reg <= 1'b0;
            int_status_reg <= usbf_pkg::INT_RESET;
            int_mask_reg <= usbf_pkg::INT_RESET;
            irq_reg <= 1'b0;
            rdata_reg <= usbf_pkg::STATUS_RESET;
        end else begin
            bulk_out_pending_reg <= bulk_out_pending_next;
            bulk_out_read_seen_reg <= bulk_out_read_seen_next;
            control_rx_read_seen_reg <= control_rx_read_seen_next;
            bulk_out_toggle_reg <= bulk_out_toggle_next;
            bulk_in_toggle_reg <= bulk_in_toggle_next;
            int_status_reg <= int_status_next;
            int_mask_reg <= int_mask_next;
            irq_reg <= irq_next;
            rdata_reg <= rdata_next;
        end
    end

    assign rdata = rdata_reg;
    assign irq = irq_reg;
    assign bulk_out_fifo_toggle = bulk_out_toggle_reg;
    assign bulk_in_fifo_toggle = bulk_in_toggle_reg;
endmodule

// ### usbf_eps_assertions.sv
// Checker module for the FIFO status-flag block, bound to its top-level ports.
`timescale 1ns/1ns
module usbf_eps_checker (
    input wire logic clk,
    input wire logic rst_b,
    input wire logic [usbf_pkg::ADDR_W-1:0] addr,
    input wire logic [usbf_pkg::DATA_W-1:0] wdata,
    input wire logic wr,
    input wire logic rd,
    input wire logic [usbf_pkg::DATA_W-1:0] rdata,
    input wire logic irq,
    input wire logic bulk_out_fifo_toggle,
    input wire logic bulk_in_sie_empty,
    input wire logic bulk_in_fifo_toggle
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_b);
    a_read_idle_zero: assert property (!$past(rd) |-> rdata == 8'h00)
        else $error("read data seen outside a read cycle");
    a_status_pad_zero: assert property ($past(rd) && $past(addr) == usbf_pkg::ADDR_STATUS
        |-> rdata[7:5] == 3'h0 && !rdata[3]) else $error("status padding bits not zero");
    a_unmapped_zero: assert property ($past(rd) && $past(addr) > usbf_pkg::ADDR_INT_MASK
        |-> rdata == 8'h00) else $error("unmapped read not zero");
    a_out_pulse_once: assert property (bulk_out_fifo_toggle |=> !bulk_out_fifo_toggle)
        else $error("bulk-out toggle longer than one cycle");
    a_in_toggle_cause: assert property (bulk_in_fifo_toggle |-> $past(bulk_in_sie_empty))
        else $error("bulk-in toggle without empty engine side");
    a_in_pulse_once: assert property (bulk_in_fifo_toggle |=> !bulk_in_fifo_toggle)
        else $error("bulk-in toggle longer than one cycle");
    a_ctx_end_sets: assert property (wr && addr == usbf_pkg::ADDR_DATA_END && wdata[1] ##1
        rd && addr == usbf_pkg::ADDR_STATUS |=> rdata[1]) else $error("control-tx flag not set");
    a_bin_end_sets: assert property (wr && addr == usbf_pkg::ADDR_DATA_END && wdata[2] ##1
        rd && addr == usbf_pkg::ADDR_STATUS |=> rdata[2]) else $error("bulk-in flag not set");
    a_irq_masked_off: assert property (wr && addr == usbf_pkg::ADDR_INT_MASK && wdata == 8'h00
        ##1 !(wr && addr == usbf_pkg::ADDR_INT_MASK) |=> !irq) else $error("irq high with mask clear");
endmodule
bind usbf_eps usbf_eps_checker i_usbf_eps_checker (.*);

// ### usbf_sie_model.sv
// Engine-side model of the bulk-in FIFO that drains for a while after each toggle.
`timescale 1ns/1ns
module usbf_sie_model #(parameter int DRAIN = 8) (
    input wire logic clk,
    input wire logic rst_b,
    input wire logic bulk_in_fifo_toggle,
    output logic bulk_in_sie_empty
);
    logic [3:0] left_reg, left_next;
    always_comb begin
        left_next = left_reg;
        if (bulk_in_fifo_toggle) begin
            left_next = 4'(DRAIN);
        end else if (left_reg != 4'h0) begin
            left_next = left_reg - 4'h1;
        end
    end
    always_ff @(posedge clk) begin
        left_reg <= rst_b ? left_next : 4'h0;
    end
    assign bulk_in_sie_empty = left_reg == 4'h0;
endmodule

// ### usbf_eps_tb_top.sv
// Self-checking testbench for the FIFO status-flag block.
`timescale 1ns/1ns
module usbf_eps_tb_top;
    logic clk, rst_b, wr, rd, bo_rd, cr_rd, ct_ok, irq, bo_tog, bi_tog, bi_empty;
    logic [7:0] addr, wdata, rdata;
    logic [6:0] bo_cnt, cr_cnt, bi_cnt;
    usbf_pkg::usbf_rx_pkt_type bo_pkt, cr_pkt;
    int error_cnt = 0, total_checks = 0, n_bo = 0, n_bi = 0, seed = 13, r;
    usbf_eps i_usbf_eps (.clk(clk), .rst_b(rst_b), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd),
        .rdata(rdata), .irq(irq), .bulk_out_pkt(bo_pkt), .bulk_out_cpu_read(bo_rd),
        .bulk_out_count(bo_cnt), .bulk_out_fifo_toggle(bo_tog), .control_rx_pkt(cr_pkt),
        .control_rx_cpu_read(cr_rd), .control_rx_count(cr_cnt), .bulk_in_count(bi_cnt),
        .bulk_in_sie_empty(bi_empty), .bulk_in_fifo_toggle(bi_tog), .control_tx_ok(ct_ok));
    usbf_sie_model i_usbf_sie_model (.clk(clk), .rst_b(rst_b), .bulk_in_fifo_toggle(bi_tog),
        .bulk_in_sie_empty(bi_empty));
    initial begin
        clk = 1'b0;
        forever #50 clk = ~clk;
    end
    always @(posedge clk) begin
        n_bo = n_bo + int'(bo_tog === 1'b1);
        n_bi = n_bi + int'(bi_tog === 1'b1);
    end
    task automatic tick(input int n);
        repeat (n) @(posedge clk);
    endtask
    task automatic chk(input logic [7:0] g, input logic [7:0] e);
        total_checks++;
        if (g !== e) begin
            error_cnt++;
            $display("[ERR] %0t: got %h, expected %h", $time, g, e);
        end
    endtask
    task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
        addr <= a;
        wdata <= d;
        wr <= 1'b1;
        tick(1);
        wr <= 1'b0;
    endtask
    task automatic rd_chk(input logic [7:0] a, input logic [7:0] e);
        addr <= a;
        rd <= 1'b1;
        tick(1);
        rd <= 1'b0;
        #1 chk(rdata, e);
        tick(1);
    endtask
    task automatic pkt(input logic ctl, input logic z);
        cr_pkt <= '{ctl, z};
        bo_pkt <= '{!ctl, z};
        tick(1);
        {cr_pkt, bo_pkt} <= 4'h0;
    endtask
    task automatic cpu_rd(input logic ctl);
        cr_rd <= ctl;
        bo_rd <= !ctl;
        tick(1);
        {cr_rd, bo_rd} <= 2'h0;
    endtask
    task automatic test_done;
        $display("Checks %0d, mismatches %0d", total_checks, error_cnt);
        if (error_cnt == 0 && total_checks > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask
    initial begin
        #400000;
        error_cnt++;
        test_done;
    end
    initial begin
        {rst_b, wr, rd, bo_rd, cr_rd, ct_ok, cr_pkt, bo_pkt} = 10'h000;
        {addr, wdata, bo_cnt, cr_cnt, bi_cnt} = 37'h0000000000;
        tick(5);
        rst_b <= 1'b1;
        tick(1);
        rd_chk(8'h00, 8'h00);
        pkt(1'b0, 1'b1);
        tick(4);
        rd_chk(8'h00, 8'h00);
        #1 chk(8'(n_bo), 8'h00);
        tick(1);
        pkt(1'b0, 1'b0);
        tick(3);
        rd_chk(8'h00, 8'h10);
        #1 chk(8'(n_bo), 8'h01);
        tick(1);
        r = $random(seed);
        bo_cnt <= 7'(r) | 7'h01;
        cpu_rd(1'b0);
        tick(3);
        rd_chk(8'h00, 8'h10);
        bo_cnt <= 7'h00;
        cpu_rd(1'b0);
        tick(3);
        rd_chk(8'h00, 8'h00);
        pkt(1'b1, 1'b1);
        tick(2);
        rd_chk(8'h00, 8'h00);
        pkt(1'b1, 1'b0);
        rd_chk(8'h00, 8'h01);
        r = $random(seed);
        cr_cnt <= 7'(r) | 7'h01;
        cpu_rd(1'b1);
        tick(3);
        rd_chk(8'h00, 8'h01);
        cr_cnt <= 7'h00;
        tick(2);
        rd_chk(8'h00, 8'h00);
        $display("receive flag tests done");
        wr_reg(8'h00, 8'hFF);
        tick(4);
        rd_chk(8'h00, 8'h00);
        rd_chk(8'h09, 8'h00);
        wr_reg(8'h01, 8'h04);
        rd_chk(8'h00, 8'h04);
        rd_chk(8'h00, 8'h00);
        bi_cnt <= 7'(r) | 7'h01;
        wr_reg(8'h01, 8'h04);
        tick(1);
        rd_chk(8'h00, 8'h04);
        tick(12);
        rd_chk(8'h00, 8'h00);
        #1 chk(8'(n_bi), 8'h02);
        tick(1);
        wr_reg(8'h01, 8'h02);
        rd_chk(8'h00, 8'h02);
        tick(5);
        rd_chk(8'h00, 8'h02);
        ct_ok <= 1'b1;
        tick(1);
        ct_ok <= 1'b0;
        rd_chk(8'h00, 8'h00);
        $display("transmit flag tests done");
        rd_chk(8'h02, 8'h0F);
        for (int i = 0; i < 7; i++) begin
            r = (i == 0) ? 0 : ((i == 6) ? 15 : $random(seed) & 15);
            wr_reg(8'h03, 8'(r));
            tick(1);
            #1 chk({7'h00, irq}, {7'h00, r != 0});
            tick(1);
        end
        wr_reg(8'h02, 8'h0F);
        rd_chk(8'h02, 8'h00);
        #1 chk({7'h00, irq}, 8'h00);
        $display("interrupt tests done");
        wr_reg(8'h01, 8'h02);
        rst_b <= 1'b0;
        tick(2);
        rst_b <= 1'b1;
        tick(1);
        rd_chk(8'h00, 8'h00);
        rd_chk(8'h03, 8'h00);
        #1 chk({7'h00, irq}, 8'h00);
        $display("reset tests done");
        test_done;
    end
endmodule
